// ==== tau_hold_reg.sv ====
`timescale 1ns/1ns
`default_nettype none
// One flash write holding byte
module tau_hold_reg (
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic       load,
   input  wire logic [7:0] din,
   output logic      [7:0] q
);
   logic [7:0] next_q;

   // Load only when selected
   always_comb begin
      next_q = load ? din : q;
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         q <= tau_pkg::HOLD_RST;
      end else begin
         q <= next_q;
      end
   end
endmodule : tau_hold_reg
`default_nettype wire

// ==== tau_pkg.sv ====
`default_nettype none
package tau_pkg;
   // Pointer and data widths
   localparam int PTR_W = 21;
   localparam int DAT_W = 8;
   localparam int HOLD_N = 8;
   localparam int HOLD_IW = 3;
   // Opcode layout: upper fourteen bits fixed, low two bits the mode
   localparam logic [13:0] OP_RD_HI = 14'h0002;
   localparam logic [13:0] OP_WT_HI = 14'h0003;
   localparam int OP_MODE_LSB = 0;
   // Pointer update modes
   typedef enum logic [1:0] {
      TAU_KEEP = 2'b00,
      TAU_POST_INC = 2'b01,
      TAU_POST_DEC = 2'b10,
      TAU_PRE_INC = 2'b11
   } tau_mode_t;
   // Reset values
   localparam logic [20:0] PTR_RST = 21'h00_0000;
   localparam logic [7:0] LATCH_RST = 8'h00;
   localparam logic [7:0] HOLD_RST = 8'hFF;
endpackage : tau_pkg
`default_nettype wire

// ==== tau_pm_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// Program memory stand-in: each word is built from its own address
module tau_pm_model (
   input  wire logic        ref_clk,
   input  wire logic        pm_rd,
   input  wire logic [19:0] pm_word_addr,
   output logic      [15:0] pm_word
);
   logic [15:0] last = 16'h0000;
   // Keep the last word so the idle bus can show its inverse
   always @(posedge ref_clk) begin
      if (pm_rd) begin
         last <= pm_word;
      end
   end
   // Idle bus never shows stale data
   assign pm_word = pm_rd ? {pm_word_addr[7:0] ^ 8'hA5, pm_word_addr[7:0]} : ~last;
endmodule : tau_pm_model
`default_nettype wire

// ==== tau_table_access.sv ====
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Table read loads the addressed program memory byte into the table latch.
// - Table pointer is a 21-bit byte address over 2 Mbyte.
// - Read: pointer bit 0 picks low or high byte of program word.
// - Read pointer modes: keep, post-increment, post-decrement, pre-increment.
// - Read opcode is 0000 0000 0000 10 plus two mode bits.
// - Write opcode is 0000 0000 0000 11 plus two mode bits.
// - Write copies latch into holding register chosen by pointer bits 2:0.
// - Write loads a holding register only, never program memory.
// - Write uses same pointer modes; pre-increment updates before selecting.
// - Write: pointer bit 0 picks low or high byte of the word.
module tau_table_access #(
   parameter int PTR_W = tau_pkg::PTR_W
) (
   input  wire logic              ref_clk,
   input  wire logic              reset_n,
   input  wire logic              instr_valid,
   input  wire logic [15:0]       instr_word,
   input  wire logic              ptr_load,
   input  wire logic [PTR_W-1:0]  ptr_load_val,
   input  wire logic              latch_load,
   input  wire logic [7:0]        latch_load_val,
   input  wire logic [15:0]       pm_word,
   output logic                   busy,
   output logic                   done,
   output logic      [PTR_W-2:0]  pm_word_addr,
   output logic                   pm_rd,
   output logic      [PTR_W-1:0]  table_pointer,
   output logic      [7:0]        table_latch,
   output logic      [63:0]       hold_bytes,
   output logic                   status_we
);
   typedef enum logic [0:0] {
      TAU_IDLE = 1'b0,
      TAU_EXEC = 1'b1
   } tau_state_t;

   tau_state_t          state;
   tau_state_t          next_state;
   logic                op_write;
   logic                next_op_write;
   tau_pkg::tau_mode_t  mode;
   tau_pkg::tau_mode_t  next_mode;
   logic [PTR_W-1:0]    next_pointer;
   logic [7:0]          next_latch;
   logic                next_done;
   logic [PTR_W-1:0]    access_addr;
   logic                is_rd;
   logic                is_wt;
   logic [7:0]          hold_load;
   // One-step pointer change at full width, so no operand is padded
   localparam logic [PTR_W-1:0] PTR_STEP = PTR_W'(1);

   // Opcode decode, fixed upper bits then mode field
   assign is_rd = (instr_word[15:2] == tau_pkg::OP_RD_HI);
   assign is_wt = (instr_word[15:2] == tau_pkg::OP_WT_HI);

   // Pre-increment addresses the bumped pointer; others the current one
   always_comb begin
      if (mode == tau_pkg::TAU_PRE_INC) begin
         access_addr = table_pointer + PTR_STEP;
      end else begin
         access_addr = table_pointer;
      end
   end

   // Word address to memory, byte picked below by bit 0
   assign pm_word_addr = access_addr[PTR_W-1:1];
   assign pm_rd = (state == TAU_EXEC) && !op_write;
   assign busy = (state == TAU_EXEC);
   assign status_we = 1'b0;

   // Sequencer and pointer/latch next values
   always_comb begin
      next_state = state;
      next_op_write = op_write;
      next_mode = mode;
      next_pointer = table_pointer;
      next_latch = table_latch;
      next_done = 1'b0;
      hold_load = 8'h00;
      unique case (state)
         TAU_IDLE: begin
            // Software side loads only while no table op runs
            if (ptr_load) begin
               next_pointer = ptr_load_val;
            end
            if (latch_load) begin
               next_latch = latch_load_val;
            end
            if (instr_valid && (is_rd || is_wt)) begin
               next_state = TAU_EXEC;
               next_op_write = is_wt;
               next_mode = tau_pkg::tau_mode_t'(instr_word[1:0]);
            end
         end
         TAU_EXEC: begin
            next_state = TAU_IDLE;
            next_done = 1'b1;
            if (op_write) begin
               // Holding byte only; flash untouched here
               hold_load[access_addr[2:0]] = 1'b1;
            end else if (access_addr[0]) begin
               next_latch = pm_word[15:8];
            end else begin
               next_latch = pm_word[7:0];
            end
            // Wraps naturally at pointer width
            unique case (mode)
               tau_pkg::TAU_KEEP: next_pointer = table_pointer;
               tau_pkg::TAU_POST_INC: next_pointer = table_pointer + PTR_STEP;
               tau_pkg::TAU_POST_DEC: next_pointer = table_pointer - PTR_STEP;
               tau_pkg::TAU_PRE_INC: next_pointer = access_addr;
            endcase
         end
      endcase
   end

   // State registers
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         state <= TAU_IDLE;
         op_write <= 1'b0;
         mode <= tau_pkg::TAU_KEEP;
         table_pointer <= tau_pkg::PTR_RST[PTR_W-1:0];
         table_latch <= tau_pkg::LATCH_RST;
         done <= 1'b0;
      end else begin
         state <= next_state;
         op_write <= next_op_write;
         mode <= next_mode;
         table_pointer <= next_pointer;
         table_latch <= next_latch;
         done <= next_done;
      end
   end

   // Eight holding bytes, one instance each
   for (genvar g = 0; g < tau_pkg::HOLD_N; g++) begin : g_hold
      tau_hold_reg u_hold (
         .ref_clk (ref_clk),
         .reset_n (reset_n),
         .load    (hold_load[g]),
         .din     (table_latch),
         .q       (hold_bytes[g*8 +: 8])
      );
   end

   // Sequencing: one execute cycle, then a single done pulse
   a_exec_one_cycle: assert property (@(posedge ref_clk) disable iff (!reset_n)
      busy |=> !busy && done)
      else $error("exec not one cycle");
   a_done_pulse: assert property (@(posedge ref_clk) disable iff (!reset_n)
      done |=> !done)
      else $error("done held too long");

   // Decode: only the two opcode groups start, and only from idle
   a_start_decode: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (!busy && instr_valid && instr_word[15:3] == 13'h0001) |=> busy)
      else $error("no start");
   a_write_decode: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (!busy && instr_valid && instr_word[15:2] == tau_pkg::OP_WT_HI) |=> busy && op_write)
      else $error("write not decoded");
   a_ignore_foreign: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (!busy && instr_valid && instr_word[15:3] != 13'h0001) |=> !busy)
      else $error("foreign opcode started");
   a_ptr_load_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (!busy && ptr_load) |=> table_pointer == $past(ptr_load_val))
      else $error("pointer load lost");

   // Read path: the addressed byte of the addressed word lands in the latch
   a_read_addr: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (busy && !op_write && mode != tau_pkg::TAU_PRE_INC)
      |-> pm_rd && pm_word_addr == table_pointer[PTR_W-1:1])
      else $error("read address wrong");
   a_pre_inc_rd: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (busy && !op_write && mode == tau_pkg::TAU_PRE_INC)
      |-> pm_rd && pm_word_addr == table_pointer[PTR_W-1:1] + (PTR_W-1)'(table_pointer[0]))
      else $error("pre inc read address wrong");
   a_read_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (busy && !op_write && !access_addr[0]) |=> table_latch == $past(pm_word[7:0]))
      else $error("low byte wrong");
   a_read_high: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (busy && !op_write && access_addr[0]) |=> table_latch == $past(pm_word[15:8]))
      else $error("high byte wrong");

   // Pointer update, wrapping at the pointer width
   a_post_inc: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (busy && mode == tau_pkg::TAU_POST_INC)
      |=> table_pointer == $past(table_pointer) + PTR_STEP)
      else $error("post inc wrong");
   a_post_dec: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (busy && mode == tau_pkg::TAU_POST_DEC)
      |=> table_pointer == $past(table_pointer) - PTR_STEP)
      else $error("post dec wrong");
   a_keep_ptr: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (busy && mode == tau_pkg::TAU_KEEP) |=> $stable(table_pointer))
      else $error("ptr moved");

   // Write path: one holding byte loads; latch and memory are left alone
   a_write_data: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (busy && op_write && mode != tau_pkg::TAU_PRE_INC)
      |=> hold_bytes[$past(table_pointer[2:0])*8 +: 8] == $past(table_latch))
      else $error("holding byte wrong");
   a_pre_inc_wr: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (busy && op_write && mode == tau_pkg::TAU_PRE_INC)
      |=> hold_bytes[$past(table_pointer[2:0] + 3'h1)*8 +: 8] == $past(table_latch))
      else $error("pre inc write wrong");
   a_write_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (busy && op_write) |-> $onehot(hold_load) && !pm_rd)
      else $error("hold select");
   a_write_no_latch: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (busy && op_write) |=> $stable(table_latch))
      else $error("latch changed");
   a_hold_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (!busy || !op_write) |-> hold_load == 8'h00)
      else $error("holding byte loaded outside a write");

   // Main scenarios reached
   c_read: cover property (@(posedge ref_clk) busy && !op_write);
   c_write: cover property (@(posedge ref_clk) busy && op_write);
   c_wrap: cover property (@(posedge ref_clk) busy && mode == tau_pkg::TAU_POST_INC
      && &table_pointer);
   c_dec_wrap: cover property (@(posedge ref_clk) busy && mode == tau_pkg::TAU_POST_DEC
      && ~|table_pointer);
   c_pre_inc_wr: cover property (@(posedge ref_clk) busy && op_write
      && mode == tau_pkg::TAU_PRE_INC);
endmodule : tau_table_access
`default_nettype wire

// ==== test_table_access_unit.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_table_access_unit;
   logic        ref_clk = 0, reset_n = 0, instr_valid = 0, ptr_load = 0, latch_load = 0;
   logic        busy, done, pm_rd, status_we;
   logic [15:0] instr_word = 16'h0000, pm_word;
   logic [19:0] pm_word_addr;
   logic [20:0] ptr_load_val = 21'h00_0000, table_pointer, ep = 21'h00_0000;
   logic [7:0]  latch_load_val = 8'h00, table_latch, el = 8'h00;
   logic [63:0] hold_bytes, eh = 64'hFFFF_FFFF_FFFF_FFFF;
   int          err_count = 0, n_compared = 0, cyc = 0;
   tau_table_access tau_table_access_i (
      .ref_clk        (ref_clk),
      .reset_n        (reset_n),
      .instr_valid    (instr_valid),
      .instr_word     (instr_word),
      .ptr_load       (ptr_load),
      .ptr_load_val   (ptr_load_val),
      .latch_load     (latch_load),
      .latch_load_val (latch_load_val),
      .pm_word        (pm_word),
      .busy           (busy),
      .done           (done),
      .pm_word_addr   (pm_word_addr),
      .pm_rd          (pm_rd),
      .table_pointer  (table_pointer),
      .table_latch    (table_latch),
      .hold_bytes     (hold_bytes),
      .status_we      (status_we)
   );
   tau_pm_model tau_pm_model_i (
      .ref_clk      (ref_clk),
      .pm_rd        (pm_rd),
      .pm_word_addr (pm_word_addr),
      .pm_word      (pm_word)
   );
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end
   // Hang guard, far above the roughly fifty cycles the run needs
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         test_done();
      end
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic test_done();
      $display("compared %0d, errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : test_done
   task automatic set_regs(input logic [20:0] p, input logic [7:0] l);
      ptr_load = 1'b1;
      latch_load = 1'b1;
      ptr_load_val = p;
      latch_load_val = l;
      @(negedge ref_clk);
      ptr_load = 1'b0;
      latch_load = 1'b0;
      ep = p;
      el = l;
   endtask : set_regs
   // One instruction; poke retries a write and a pointer load while busy
   task automatic op(input logic [15:0] w, input logic poke);
      logic [20:0] a;
      int n;
      a = (w[1:0] == 2'd3) ? ep + 21'h00_0001 : ep;
      instr_word = w;
      instr_valid = 1'b1;
      @(negedge ref_clk);
      chk(busy, 1'b1);
      chk(pm_rd, !w[2]);
      if (!w[2]) chk(pm_word_addr, a[20:1]);
      instr_valid = poke;
      ptr_load = poke;
      instr_word = 16'h000C;
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (done !== 1'b1 && n < 4);
      if (w[2]) eh[a[2:0]*8 +: 8] = el;
      else el = a[0] ? (a[8:1] ^ 8'hA5) : a[8:1];
      if (w[1:0] == 2'd2) ep = ep - 21'h00_0001;
      else if (w[1:0] != 2'd0) ep = ep + 21'h00_0001;
      chk(n, 1);
      chk(busy, 1'b0);
      chk(table_pointer, ep);
      chk(table_latch, el);
      chk(hold_bytes, eh);
      chk(status_we, 1'b0);
      if (poke) begin
         instr_valid = 1'b0;
         ptr_load = 1'b0;
         @(negedge ref_clk);
         chk(done, 1'b0);
      end
   endtask : op
   task automatic t_reset();
      chk(table_pointer, 21'h00_0000);
      chk(table_latch, 8'h00);
      chk(hold_bytes, eh);
   endtask : t_reset
   // Reset in mid-run returns every register to its reset value
   task automatic t_reset_again();
      reset_n = 1'b0;
      @(negedge ref_clk);
      reset_n = 1'b1;
      ep = 21'h00_0000;
      el = 8'h00;
      eh = 64'hFFFF_FFFF_FFFF_FFFF;
      @(negedge ref_clk);
      t_reset();
      chk(busy, 1'b0);
      chk(done, 1'b0);
   endtask : t_reset_again
   // Every mode of both opcodes, back to back, at both wrap edges
   task automatic t_modes();
      logic [20:0] s[2] = '{21'h1F_FFFF, 21'h00_0000};
      for (int i = 0; i < 2; i++) begin
         for (int m = 0; m < 4; m++) begin
            // Start one step short of the wrap in the direction of the mode
            set_regs((m == 2) ? s[i] + 21'h00_0001 : s[i] - 21'(m & 1), 8'h3C);
            op(16'h0008 | 16'(m), 1'b0);
            op(16'h000C | 16'(m), 1'b0);
         end
      end
   endtask : t_modes
   // Requests during the busy cycle and a foreign opcode are ignored
   task automatic t_refused();
      set_regs(21'h0A_3456, 8'h55);
      op(16'h0009, 1'b1);
      instr_word = 16'h0010;
      instr_valid = 1'b1;
      @(negedge ref_clk);
      instr_valid = 1'b0;
      chk(busy, 1'b0);
      chk(table_pointer, ep);
   endtask : t_refused
   initial begin
      repeat (3) @(negedge ref_clk);
      reset_n = 1'b1;
      @(negedge ref_clk);
      t_reset();
      t_modes();
      t_refused();
      t_reset_again();
      test_done();
   end
endmodule : test_table_access_unit
`default_nettype wire
